// ===== pcs_pkg.sv
/*
  Shared constants for the clock source control block: the layout of the
  synthesizer control word, divider decoding, source codes and timing.
  Assumes a single 200 MHz system clock drives every register.
*/
package pcs_pkg;

  // ---------------------------------------------
  // control word layout
  // ---------------------------------------------
  localparam int CTRL_W = 16;
  localparam int POWER_BIT = 15;
  localparam int SELECT_BIT = 14;
  localparam int LF_LSB = 8;
  localparam int LF_W = 4;
  localparam int NCODE_LSB = 5;
  localparam int NCODE_W = 3;
  localparam int MCODE_LSB = 0;
  localparam int MCODE_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;

  // ---------------------------------------------
  // divider coding
  // ---------------------------------------------
  localparam logic [NCODE_W-1:0] NCODE_ONE = 3'h7;
  localparam logic [5:0] M_OFFSET = 6'h02;
  localparam logic [3:0] N_OFFSET = 4'h2;
  localparam logic [3:0] N_MIN = 4'h1;

  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int REF_TIMEOUT_NS = 2000;
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int LOCK_WINDOWS = 8;
  localparam int SLOW_HALF_CYC = 32;

  // ---------------------------------------------
  // clock sources
  // ---------------------------------------------
  typedef enum logic [1:0] {
    PCS_SRC_REF,
    PCS_SRC_SYNTH,
    PCS_SRC_SLOW
  } pcs_src_e;

  function automatic logic [5:0] pcs_m_value(input logic [MCODE_W-1:0] code);
    pcs_m_value = {1'b0, code} + M_OFFSET;
  endfunction

  function automatic logic [3:0] pcs_n_value(input logic [NCODE_W-1:0] code);
    if (code == NCODE_ONE) begin
      pcs_n_value = N_MIN;
    end else begin
      pcs_n_value = {1'b0, code} + N_OFFSET;
    end
  endfunction

endpackage

// ===== pcs_lock_detect.sv
/*
  Lock detector: counts synthesizer edges over a window of N reference
  edges and reports lock after several windows that each hold M edges.
  Assumes edge pulses already synchronised into the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_lock_detect
  import pcs_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic active, // detection running
  input wire logic ref_rise, // reference edge pulse
  input wire logic vco_rise, // synthesizer edge pulse
  input wire logic [5:0] m_val, // feedback divide
  input wire logic [3:0] n_val, // input divide
  output logic lock_hit // one-cycle lock pulse
);

  // ---------------------------------------------
  // window counters
  // ---------------------------------------------
  logic [3:0] ref_cnt_q, ref_cnt_d;
  logic [5:0] vco_cnt_q, vco_cnt_d;
  logic [3:0] good_q, good_d;
  logic [15:0] idle_q, idle_d;
  logic win_end, win_ok, ref_lost;

  assign ref_lost = (idle_q >= 16'(REF_TIMEOUT_CYC));
  assign win_end = ref_rise && (ref_cnt_q + 4'h1 >= n_val);
  assign win_ok = (vco_cnt_q == m_val);
  assign lock_hit = active && win_end && win_ok
                    && (good_q == 4'(LOCK_WINDOWS - 1));

  always_comb begin
    ref_cnt_d = ref_cnt_q;
    vco_cnt_d = vco_cnt_q;
    good_d = good_q;
    idle_d = ref_rise ? 16'h0000 : (ref_lost ? idle_q : idle_q + 16'h0001);
    if (!active || ref_lost) begin
      ref_cnt_d = 4'h0;
      vco_cnt_d = 6'h00;
      good_d = 4'h0;
    end else begin
      if (vco_rise && vco_cnt_q != 6'h3f) begin
        vco_cnt_d = vco_cnt_q + 6'h01;
      end
      if (win_end) begin
        ref_cnt_d = 4'h0;
        vco_cnt_d = {5'h00, vco_rise};
        good_d = win_ok ? good_q + 4'h1 : 4'h0;
      end else if (ref_rise) begin
        ref_cnt_d = ref_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_cnt_q <= 4'h0;
      vco_cnt_q <= 6'h00;
      good_q <= 4'h0;
      idle_q <= 16'h0000;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      vco_cnt_q <= vco_cnt_d;
      good_q <= good_d;
      idle_q <= idle_d;
    end
  end

endmodule

`default_nettype wire

// ===== pcs_clock_source.sv
/*
  Processor clock source control: synthesizer control word, lock flag,
  ring oscillator and a glitch-free switch between reference, synthesizer
  half rate and slow oscillator. Assumes reference and synthesizer clocks
  arrive as pins far slower than clk; power control bits come from logic
  on clk.
*/
// What this block does
// - choose reference, synthesizer or slow oscillator
// - run from reference after powerup
// - power control overrides synthesizer selection
// - no synthesizer lock without reference edges
// - set lock, then stop detecting until cleared
// - select moves to half synthesizer rate, glitch-free
// - any control write clears the lock flag
// - synthesizer tracks held divider settings continuously
// - synthesizer rate is reference times M over N
// - M code is M-2; N code 7 or N-2
// - power bit zero powers synthesizer down
// - select zero gives 1X reference copy
// - control word clears to zero on reset
// - switch synchronous, old rate until done
// - switch to synthesizer in 1 to N+2 cycles
// - switch back in M/N+1 to M+M/N+1 cycles
// - slow select uses ring oscillator, off once the active source leaves it
`timescale 1ns/1ps
`default_nettype none

module pcs_clock_source
  import pcs_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic ctrl_write, // control word write strobe
  input wire logic [CTRL_W-1:0] ctrl_wdata, // control word write data
  output logic [CTRL_W-1:0] ctrl_rdata, // control word readback
  input wire logic slow_osc_select, // force ring oscillator source
  input wire logic clocks_stop, // stop processor clock
  input wire logic ref_clock_in, // reference clock pin
  input wire logic vco_clock_in, // synthesizer oscillator pin
  output logic synth_power_on, // synthesizer power enable
  output logic synth_source_select, // synthesizer selected bit
  output logic [MCODE_W-1:0] feedback_div_code, // M code to synthesizer
  output logic [NCODE_W-1:0] input_div_code, // N code to synthesizer
  output logic [LF_W-1:0] loop_filter_code, // loop filter code
  output logic lock_flag, // synthesizer locked
  output logic slow_osc_power, // ring oscillator running
  output logic proc_clock, // internal processor clock
  output logic clock_output_pin, // clock output pin
  output logic switch_busy, // source change in progress
  output logic [1:0] active_source // source now driving clock
);

  // ---------------------------------------------
  // pin synchronisers and edge pulses
  // ---------------------------------------------
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic vco_s1_q, vco_s2_q, vco_s3_q;
  logic ref_rise, vco_rise;
  logic [CTRL_W-1:0] ctrl_q;
  pcs_src_e cur_src_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      vco_s1_q <= 1'b0;
      vco_s2_q <= 1'b0;
      vco_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_clock_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      vco_s1_q <= vco_clock_in;
      vco_s2_q <= vco_s1_q;
      vco_s3_q <= vco_s2_q;
    end
  end

  assign ref_rise = ref_s2_q && !ref_s3_q;
  assign vco_rise = vco_s2_q && !vco_s3_q && ctrl_q[POWER_BIT];

  // ---------------------------------------------
  // control word and lock flag
  // ---------------------------------------------
  logic lock_q, lock_d, lock_hit;
  logic [5:0] m_val;
  logic [3:0] n_val;

  assign m_val = pcs_m_value(ctrl_q[MCODE_LSB +: MCODE_W]);
  assign n_val = pcs_n_value(ctrl_q[NCODE_LSB +: NCODE_W]);

  // detection is idle while locked, until a write clears the flag
  always_comb begin
    lock_d = lock_q;
    if (ctrl_write) begin
      lock_d = 1'b0;
    end
    if (lock_hit) begin
      lock_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RESET;
      lock_q <= 1'b0;
    end else begin
      if (ctrl_write) begin
        ctrl_q <= ctrl_wdata;
      end
      lock_q <= lock_d;
    end
  end

  // synthesizer follows whatever divider settings are held
  pcs_lock_detect u_lock (
    .clk(clk),
    .reset_n(reset_n),
    .active(ctrl_q[POWER_BIT] && !lock_q && !ctrl_write),
    .ref_rise(ref_rise),
    .vco_rise(vco_rise),
    .m_val(m_val),
    .n_val(n_val),
    .lock_hit(lock_hit)
  );

  assign ctrl_rdata = ctrl_q;
  assign synth_power_on = ctrl_q[POWER_BIT];
  assign synth_source_select = ctrl_q[SELECT_BIT];
  assign feedback_div_code = ctrl_q[MCODE_LSB +: MCODE_W];
  assign input_div_code = ctrl_q[NCODE_LSB +: NCODE_W];
  assign loop_filter_code = ctrl_q[LF_LSB +: LF_W];
  assign lock_flag = lock_q;

  // ---------------------------------------------
  // source levels
  // ---------------------------------------------
  logic vco_half_q;
  logic [5:0] slow_cnt_q;
  logic slow_lvl_q;
  logic slow_run;

  // ring oscillator runs while selected and until cur_src_q leaves PCS_SRC_SLOW, before the switch away is done
  assign slow_run = slow_osc_select || (cur_src_q == PCS_SRC_SLOW);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vco_half_q <= 1'b0;
      slow_cnt_q <= 6'h00;
      slow_lvl_q <= 1'b0;
    end else begin
      if (vco_rise) begin
        vco_half_q <= !vco_half_q;
      end
      if (!slow_run) begin
        slow_cnt_q <= 6'h00;
        slow_lvl_q <= 1'b0;
      end else if (slow_cnt_q == 6'(SLOW_HALF_CYC - 1)) begin
        slow_cnt_q <= 6'h00;
        slow_lvl_q <= !slow_lvl_q;
      end else begin
        slow_cnt_q <= slow_cnt_q + 6'h01;
      end
    end
  end

  assign slow_osc_power = slow_run;

  // ---------------------------------------------
  // glitch-free source switch
  // ---------------------------------------------
  typedef enum logic [1:0] {
    PCS_SW_RUN,
    PCS_SW_DRAIN,
    PCS_SW_ARM
  } pcs_sw_e;

  pcs_sw_e sw_q, sw_d;
  pcs_src_e cur_src_d, want_src;
  logic cur_lvl, new_lvl;
  logic gate_q, gate_d;
  logic clk_q, clk_d;

  function automatic logic pcs_level(input pcs_src_e src, input logic r,
                                     input logic v, input logic s);
    case (src)
      PCS_SRC_SYNTH: pcs_level = v;
      PCS_SRC_SLOW: pcs_level = s;
      default: pcs_level = r;
    endcase
  endfunction

  // power control has priority over the synthesizer select
  assign want_src = slow_osc_select ? PCS_SRC_SLOW :
                    ctrl_q[SELECT_BIT] ? PCS_SRC_SYNTH :
                    PCS_SRC_REF;
  assign cur_lvl = pcs_level(cur_src_q, ref_s2_q, vco_half_q, slow_lvl_q);
  assign new_lvl = pcs_level(want_src, ref_s2_q, vco_half_q, slow_lvl_q);

  // old source keeps running until its low phase, then the new one
  // is picked up at its own low phase, so no short pulse appears
  always_comb begin
    sw_d = sw_q;
    cur_src_d = cur_src_q;
    case (sw_q)
      PCS_SW_RUN: begin
        if (want_src != cur_src_q) begin
          sw_d = PCS_SW_DRAIN;
        end
      end
      PCS_SW_DRAIN: begin
        if (!cur_lvl) begin
          cur_src_d = want_src;
          sw_d = PCS_SW_ARM;
        end
      end
      PCS_SW_ARM: begin
        if (want_src != cur_src_q) begin
          sw_d = PCS_SW_DRAIN;
        end else if (!cur_lvl) begin
          sw_d = PCS_SW_RUN;
        end
      end
      default: begin
        sw_d = PCS_SW_RUN;
      end
    endcase
  end

  // stop gate opens and closes only while the source is low
  assign gate_d = cur_lvl ? gate_q : !clocks_stop;

  always_comb begin
    clk_d = 1'b0;
    case (sw_q)
      PCS_SW_RUN: clk_d = cur_lvl && gate_q;
      PCS_SW_DRAIN: clk_d = clk_q && cur_lvl;
      PCS_SW_ARM: clk_d = 1'b0;
      default: clk_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_q <= PCS_SW_RUN;
      cur_src_q <= PCS_SRC_REF;
      gate_q <= 1'b1;
      clk_q <= 1'b0;
    end else begin
      sw_q <= sw_d;
      cur_src_q <= cur_src_d;
      gate_q <= gate_d;
      clk_q <= clk_d;
    end
  end

  assign proc_clock = clk_q;
  assign clock_output_pin = clk_q;
  assign switch_busy = (sw_q != PCS_SW_RUN);
  assign active_source = cur_src_q;

endmodule

`default_nettype wire

// ===== pcs_clock_source_sva.sv
/*
  Port checker for the clock source block.
  Assumes one clk domain and reset_n async active low.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_clock_source_sva
  import pcs_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire logic ctrl_write, // write strobe
  input wire logic [CTRL_W-1:0] ctrl_wdata, // write data
  input wire logic [CTRL_W-1:0] ctrl_rdata, // readback
  input wire logic slow_osc_select, // ring select
  input wire logic clocks_stop, // stop
  input wire logic synth_power_on, // power bit
  input wire logic [MCODE_W-1:0] feedback_div_code, // m code
  input wire logic lock_flag, // lock
  input wire logic slow_osc_power, // ring power
  input wire logic proc_clock, // clock out
  input wire logic clock_output_pin, // pin copy
  input wire logic switch_busy, // busy
  input wire logic [1:0] active_source // source
);
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_word_load: assert property (
    ctrl_write |=> ctrl_rdata == $past(ctrl_wdata))
    else $error("control word not loaded");
  chk_word_hold: assert property (
    !ctrl_write |=> $stable(ctrl_rdata))
    else $error("control word changed without write");
  chk_field_map: assert property (
    synth_power_on == ctrl_rdata[POWER_BIT] &&
    feedback_div_code == ctrl_rdata[MCODE_W-1:0])
    else $error("field outputs differ from word");
  chk_write_clears: assert property (
    ctrl_write |=> !lock_flag)
    else $error("lock kept over a write");
  chk_lock_sticky: assert property (
    lock_flag && !ctrl_write |=> lock_flag)
    else $error("lock dropped without write");
  chk_lock_power: assert property (
    !synth_power_on |-> !lock_flag)
    else $error("lock while powered down");
  chk_slow_power: assert property (
    slow_osc_power == (slow_osc_select ||
    active_source == PCS_SRC_SLOW))
    else $error("ring power wrong");
  chk_pin_copy: assert property (
    clock_output_pin == proc_clock)
    else $error("output pin differs");
  chk_stop_low: assert property (
    clocks_stop && $past(clocks_stop) && !proc_clock |=> !proc_clock)
    else $error("clock ran while stopped");
  chk_src_stable: assert property (
    !switch_busy |=> $stable(active_source))
    else $error("source changed outside switch");
  chk_switch_bound: assert property (
    $rose(switch_busy) |-> ##[1:600] !switch_busy)
    else $error("switch did not finish");

  cov_lock: cover property ($rose(lock_flag));
  cov_synth: cover property (active_source == PCS_SRC_SYNTH);
  cov_slow: cover property (active_source == PCS_SRC_SLOW);
endmodule

bind pcs_clock_source pcs_clock_source_sva chk (.clk, .reset_n,
  .ctrl_write, .ctrl_wdata, .ctrl_rdata, .slow_osc_select,
  .clocks_stop, .synth_power_on, .feedback_div_code, .lock_flag,
  .slow_osc_power, .proc_clock, .clock_output_pin, .switch_busy,
  .active_source);

`default_nettype wire

// ===== pcs_ref_model.sv
/*
  Reference clock source and synthesizer oscillator model.
  Assumes the divider codes and power bit of the block under test.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_ref_model
  import pcs_pkg::*;
#(
  parameter real REF_NS = 200.0
)
(
  input wire logic ref_on, // reference running
  input wire logic power_on, // synthesizer powered
  input wire logic [MCODE_W-1:0] m_code, // m code
  input wire logic [NCODE_W-1:0] n_code, // n code
  output logic ref_clk, // reference pin
  output logic vco_clk // oscillator pin
);
  real m;
  real n;
  real h;
  // stopped clocks stand low
  initial begin
    ref_clk = 1'b0;
    forever begin
      if (ref_on) begin
        #(REF_NS / 2) ref_clk = 1'b1;
        #(REF_NS / 2) ref_clk = 1'b0;
      end else #5;
    end
  end
  // oscillator only with power and reference
  initial begin
    vco_clk = 1'b0;
    forever begin
      if (power_on && ref_on) begin
        m = m_code + 2;
        n = (n_code == NCODE_ONE) ? 1 : n_code + 2;
        h = REF_NS * n / (2 * m);
        @(posedge ref_clk);
        // keep oscillator edges off the clk sampling edges
        #(h / 2 + 1.0);
        while (power_on && ref_on) begin
          vco_clk = 1'b1;
          #h vco_clk = 1'b0;
          #h;
        end
      end else #5;
    end
  end
endmodule

`default_nettype wire

// ===== pcs_clock_source_bench.sv
/*
  Self-checking bench for the clock source block.
  Assumes pcs_ref_model at the pins and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_clock_source_bench
  import pcs_pkg::*;
;
  logic clk, reset_n, ctrl_write, slow_osc_select, clocks_stop, ref_on;
  logic [CTRL_W-1:0] ctrl_wdata, ctrl_rdata;
  logic ref_clock_in, vco_clock_in, synth_power_on, synth_source_select;
  logic [MCODE_W-1:0] feedback_div_code;
  logic [NCODE_W-1:0] input_div_code;
  logic [LF_W-1:0] loop_filter_code;
  logic lock_flag, slow_osc_power, proc_clock, clock_output_pin;
  logic switch_busy;
  logic [1:0] active_source;
  int fail_count, samples_checked;

  pcs_clock_source uut (.clk, .reset_n, .ctrl_write, .ctrl_wdata,
    .ctrl_rdata, .slow_osc_select, .clocks_stop, .ref_clock_in,
    .vco_clock_in, .synth_power_on, .synth_source_select,
    .feedback_div_code, .input_div_code, .loop_filter_code, .lock_flag,
    .slow_osc_power, .proc_clock, .clock_output_pin, .switch_busy,
    .active_source);
  pcs_ref_model far (.ref_on, .power_on(synth_power_on),
    .m_code(feedback_div_code), .n_code(input_div_code),
    .ref_clk(ref_clock_in), .vco_clk(vco_clock_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, wrong %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge clk);
    ctrl_write <= 1'b1;
    ctrl_wdata <= d;
    @(posedge clk);
    ctrl_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_src(input pcs_src_e s);
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (active_source === s && switch_busy === 1'b0) return;
    end
    fail_count++;
    finish_test();
  endtask
  task automatic wait_lock(input int n, input logic exp);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (lock_flag === 1'b1) break;
    end
    check({15'h0, lock_flag}, {15'h0, exp});
  endtask
  // counts processor clock rises over n cycles
  task automatic rate(input int n, input int lo, input int hi);
    int c;
    logic last;
    c = 0;
    last = proc_clock;
    repeat (n) begin
      @(posedge clk);
      if (proc_clock === 1'b1 && last === 1'b0) c++;
      last = proc_clock;
    end
    check({15'h0, c >= lo && c <= hi}, 16'h0001);
  endtask
  // ---------------------------------------------
  // sequence
  // ---------------------------------------------
  initial begin
    reset_n = 1'b0;
    ctrl_write = 1'b0;
    ctrl_wdata = 16'h0000;
    slow_osc_select = 1'b0;
    clocks_stop = 1'b0;
    ref_on = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check(ctrl_rdata, CTRL_RESET);
    check({14'h0, active_source}, {14'h0, PCS_SRC_REF});
    rate(400, 9, 11);
    $display("reset test done");
    wr(16'h29e6);
    check({13'h0, input_div_code}, 16'h0007);
    wr(16'h2906);
    check(ctrl_rdata, 16'h2906);
    check({11'h0, feedback_div_code}, 16'h0006);
    check({12'h0, loop_filter_code}, 16'h0009);
    check({15'h0, synth_power_on}, 16'h0000);
    $display("field test done");
    wr(16'ha906);
    wait_lock(3000, 1'b1);
    wr(16'ha906);
    check({15'h0, lock_flag}, 16'h0000);
    wait_lock(3000, 1'b1);
    $display("lock test done");
    wr(16'he906);
    check({15'h0, synth_source_select}, 16'h0001);
    wait_src(PCS_SRC_SYNTH);
    rate(400, 19, 21);
    wr(16'ha906);
    wait_src(PCS_SRC_REF);
    check({15'h0, synth_source_select}, 16'h0000);
    rate(400, 9, 11);
    $display("switch test done");
    @(posedge clk);
    slow_osc_select <= 1'b1;
    wait_src(PCS_SRC_SLOW);
    check({15'h0, slow_osc_power}, 16'h0001);
    rate(640, 9, 11);
    clocks_stop <= 1'b1;
    repeat (80) @(posedge clk);
    rate(300, 0, 0);
    clocks_stop <= 1'b0;
    slow_osc_select <= 1'b0;
    wait_src(PCS_SRC_REF);
    check({15'h0, slow_osc_power}, 16'h0000);
    $display("slow test done");
    wr(16'h2906);
    ref_on <= 1'b0;
    repeat (50) @(posedge clk);
    wr(16'ha906);
    wait_lock(1500, 1'b0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    check(ctrl_rdata, CTRL_RESET);
    $display("no reference test done");
    finish_test();
  end
endmodule

`default_nettype wire
